// ===== verilog/pmio_pkg.sv
// pmio_pkg: constants and types for the mode-muxed eight-pin port.
// assumes: one 40 MHz clock, registers reached over axi4-lite.
package pmio_pkg;
  // register indices as numbered; the bus sees one 32-bit word per index
  localparam logic [15:0] PMIO_IDX_DIR = 16'hFFC0;
  localparam logic [15:0] PMIO_IDX_DATA = 16'hFFC1;
  // byte address is four times the index
  localparam logic [17:0] PMIO_OFF_DIR = {PMIO_IDX_DIR, 2'h0};
  localparam logic [17:0] PMIO_OFF_DATA = {PMIO_IDX_DATA, 2'h0};
  localparam logic [7:0] PMIO_DIR_RST_EXP = 8'h40;
  localparam logic [7:0] PMIO_DIR_RST_SC = 8'h00;
  localparam logic [7:0] PMIO_DATA_RST = 8'h00;
  localparam logic [1:0] PMIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMIO_RESP_SLVERR = 2'h2;
  localparam int PMIO_PIN_CLK = 6;
  typedef enum logic [1:0] {PMIO_EXP1, PMIO_EXP2, PMIO_SINGLE} pmio_mode_e;
endpackage

// ===== verilog/pmio_regs_if.sv
// pmio_regs_if: register write strobes and values between bus slave and port core.
// assumes: single clock domain.
`timescale 1ns/100ps
interface pmio_regs_if;
  logic dir_we;
  logic data_we;
  logic [7:0] wdata;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] rd_view;
  modport slave (output dir_we, data_we, wdata, input dir, data, rd_view);
  modport core (input dir_we, data_we, wdata, output dir, data, rd_view);
endinterface

// ===== verilog/pmio_axil.sv
// pmio_axil: axi4-lite slave for the two port registers.
// assumes: one write and one read outstanding at most.
`timescale 1ns/100ps
module pmio_axil (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [17:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [17:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  pmio_regs_if.slave regs
);
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [17:0] awaddr_r, awaddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr;
  // ready lines kept in flops so no axi output is driven through a gate
  logic awready_r, wready_r, arready_r;

  // address and data taken in either order; response once both held
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_wr = 1'b0;
    if (i_awvalid && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = i_awaddr;
    end
    if (i_wvalid && !w_have_r) begin
      w_have_nxt = 1'b1;
      wbyte_nxt = i_wdata[7:0];
      wlane_nxt = i_wstrb[0];
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      do_wr = wlane_r;
      bvalid_nxt = 1'b1;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bresp_nxt = (awaddr_r[17:2] == pmio_pkg::PMIO_IDX_DIR ||
                   awaddr_r[17:2] == pmio_pkg::PMIO_IDX_DATA) ?
                  pmio_pkg::PMIO_RESP_OKAY : pmio_pkg::PMIO_RESP_SLVERR;
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    regs.wdata = wbyte_r;
    regs.dir_we = do_wr && awaddr_r[17:2] == pmio_pkg::PMIO_IDX_DIR;
    regs.data_we = do_wr && awaddr_r[17:2] == pmio_pkg::PMIO_IDX_DATA;
  end

  // direction is write-only so it reads as zero
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (i_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = pmio_pkg::PMIO_RESP_OKAY;
      if (i_araddr[17:2] == pmio_pkg::PMIO_IDX_DATA) begin
        rdata_nxt = {24'h00_0000, regs.rd_view};
      end else if (i_araddr[17:2] != pmio_pkg::PMIO_IDX_DIR) begin
        rresp_nxt = pmio_pkg::PMIO_RESP_SLVERR;
      end
    end else if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 18'h0_0000;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= !aw_have_nxt;
      wready_r <= !w_have_nxt;
      arready_r <= !rvalid_nxt;
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
endmodule

// ===== verilog/pmio_pins.sv
// pmio_pins: three-flop synchroniser for the eight pad inputs.
// assumes: pads are asynchronous to i_clk.
`timescale 1ns/100ps
module pmio_pins (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_pad,
  output logic [7:0] o_level
);
  logic [7:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

  // level moves only when stages two and three agree
  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 8; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      // park high: interrupt and strobe feeds are active low, no false request
      s1_r <= 8'hFF;
      s2_r <= 8'hFF;
      s3_r <= 8'hFF;
      lvl_r <= 8'hFF;
    end else begin
      s1_r <= i_pad;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule

// ===== verilog/pmio_port.sv
// pmio_port: mode-muxed eight-pin port with direction and data latch registers.
// assumes: mode, dual-port enable, standby and bus strobes come from on-chip
// logic on i_clk; pads are resolved by the bench from o_pad_out/o_pad_oe.
`timescale 1ns/100ps
module pmio_port (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [17:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [17:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire pmio_pkg::pmio_mode_e i_mode,
  input wire logic i_dualport_slave_enable,
  input wire logic i_hw_standby,
  input wire logic i_sw_standby,
  input wire logic i_sysclk_level,
  input wire logic i_rd_strobe_n,
  input wire logic i_wr_strobe_n,
  input wire logic i_addr_strobe_n,
  input wire logic i_ready_n,
  input wire logic [7:0] i_pad_in,
  output logic [7:0] o_pad_out,
  output logic [7:0] o_pad_oe,
  output logic [7:0] o_pullup_en,
  output logic o_ext_interrupt_zero,
  output logic o_ext_interrupt_one,
  output logic o_ext_interrupt_two,
  output logic o_converter_trigger_in,
  output logic o_chip_select_n,
  output logic o_output_enable_n,
  output logic o_write_enable_n,
  output logic o_bus_wait_n
);
  pmio_regs_if regs ();
  logic [7:0] pin_lvl;
  logic [7:0] dir_r, dir_nxt, data_r, data_nxt;
  logic [7:0] out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt;
  logic [7:0] irq_r, irq_nxt;
  logic expanded, slave;
  logic [7:0] gpio_mask;

  // axi responses come from the slave's own registers
  pmio_axil u_axil (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .regs(regs.slave)
  );

  pmio_pins u_pins (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pad(i_pad_in),
    .o_level(pin_lvl)
  );

  // function selection is purely from mode inputs
  always_comb begin
    expanded = (i_mode != pmio_pkg::PMIO_SINGLE);
    slave = !expanded && i_dualport_slave_enable;
    // pins that behave as plain i/o under the registers
    gpio_mask = 8'h07;
    if (!expanded && !slave) begin
      gpio_mask = 8'hBF;
    end
  end

  // register state; reset value of direction follows the current mode
  always_comb begin
    dir_nxt = dir_r;
    data_nxt = data_r;
    if (regs.dir_we) begin
      dir_nxt = regs.wdata;
    end
    if (regs.data_we) begin
      data_nxt = regs.wdata;
    end
  end

  // pad drive, enable and pull-up per pin
  always_comb begin
    out_nxt = out_r;
    oe_nxt = oe_r;
    pu_nxt = pu_r;
    if (i_hw_standby) begin
      oe_nxt = 8'h00;
      pu_nxt = 8'h00;
    end else if (i_sw_standby) begin
      // hold everything; bus strobes and clock parked high
      if (expanded) begin
        out_nxt[5:3] = 3'h7;
      end
      if (oe_r[pmio_pkg::PMIO_PIN_CLK]) begin
        out_nxt[pmio_pkg::PMIO_PIN_CLK] = 1'b1;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        out_nxt[i] = data_r[i];
        oe_nxt[i] = gpio_mask[i] & dir_r[i];
        pu_nxt[i] = !dir_r[i] & data_r[i];
      end
      if (expanded) begin
        out_nxt[3] = i_rd_strobe_n;
        out_nxt[4] = i_wr_strobe_n;
        out_nxt[5] = i_addr_strobe_n;
        oe_nxt[5:3] = 3'h7;
        pu_nxt[5:3] = 3'h0;
        out_nxt[6] = i_sysclk_level;
        oe_nxt[6] = 1'b1;
        pu_nxt[6] = 1'b0;
        oe_nxt[7] = 1'b0;
      end else begin
        oe_nxt[6] = dir_r[6];
        if (dir_r[6]) begin
          out_nxt[6] = i_sysclk_level;
        end
        if (slave) begin
          oe_nxt[4:3] = 2'h0;
          out_nxt[5] = i_ready_n;
          oe_nxt[5] = 1'b1;
          pu_nxt[5] = 1'b0;
          oe_nxt[7] = 1'b0;
        end
      end
    end
  end

  // alternate inputs follow the live pin level
  always_comb begin
    irq_nxt = {expanded ? pin_lvl[7] : 1'b1,
               1'b1,
               slave ? pin_lvl[7] : 1'b1,
               slave ? pin_lvl[4] : 1'b1,
               slave ? pin_lvl[3] : 1'b1,
               pin_lvl[2:0]};
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dir_r <= (i_mode != pmio_pkg::PMIO_SINGLE) ?
               pmio_pkg::PMIO_DIR_RST_EXP : pmio_pkg::PMIO_DIR_RST_SC;
      data_r <= pmio_pkg::PMIO_DATA_RST;
      out_r <= 8'hFF;
      oe_r <= 8'h00;
      pu_r <= 8'h00;
      irq_r <= 8'hFF;
    end else begin
      dir_r <= dir_nxt;
      data_r <= data_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      irq_r <= irq_nxt;
    end
  end

  // latch for outputs, live level for every input or alternate pin
  always_comb begin
    regs.dir = dir_r;
    regs.data = data_r;
    regs.rd_view = (dir_r & gpio_mask & data_r) | (~(dir_r & gpio_mask) & pin_lvl);
  end

  assign o_pad_out = out_r;
  assign o_pad_oe = oe_r;
  assign o_pullup_en = pu_r;
  assign o_ext_interrupt_two = irq_r[0];
  assign o_converter_trigger_in = irq_r[0];
  assign o_ext_interrupt_one = irq_r[1];
  assign o_ext_interrupt_zero = irq_r[2];
  assign o_chip_select_n = irq_r[3];
  assign o_output_enable_n = irq_r[4];
  assign o_write_enable_n = irq_r[5];
  assign o_bus_wait_n = irq_r[7];
endmodule

// ===== tb/pmio_port_properties.sv
// checker for the port pins: function by mode, standby and reset
// assumes: bound into pmio_port; pin outputs settle one clock after cause
`timescale 1ns/100ps
module pmio_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire pmio_pkg::pmio_mode_e i_mode,
  input wire logic i_dualport_slave_enable,
  input wire logic i_hw_standby,
  input wire logic i_sw_standby,
  input wire logic i_rd_strobe_n,
  input wire logic i_wr_strobe_n,
  input wire logic i_addr_strobe_n,
  input wire logic i_ready_n,
  input wire logic [7:0] o_pad_out,
  input wire logic [7:0] o_pad_oe,
  input wire logic [7:0] o_pullup_en,
  input wire logic o_ext_interrupt_two,
  input wire logic o_converter_trigger_in
);
  logic run;
  logic is_exp;
  logic slave;
  // mode decode shared by the properties
  // sampled reset in the antecedent: the release edge itself starts no attempt
  assign run = i_resetn && !i_hw_standby && !i_sw_standby;
  assign is_exp = i_mode != pmio_pkg::PMIO_SINGLE;
  assign slave = !is_exp && i_dualport_slave_enable && run;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  hw_release_a: assert property (i_hw_standby |=> !o_pad_oe && !o_pullup_en)
    else $error("pins held in hardware standby");
  exp_drive_a: assert property (is_exp && run |=> o_pad_oe[7:3] == 5'h0F)
    else $error("expanded pin drive wrong");
  exp_pullup_a: assert property (is_exp |=> o_pullup_en[6:3] == 4'h0)
    else $error("expanded pull-up on");
  strobe_pass_a: assert property (is_exp && run |=>
    o_pad_out[5:3] == $past({i_addr_strobe_n, i_wr_strobe_n, i_rd_strobe_n}))
    else $error("bus strobes not passed");
  sw_hold_a: assert property (is_exp && i_sw_standby && !i_hw_standby |=>
    o_pad_out[6:3] == 4'hF)
    else $error("strobes not high in standby");
  slave_dir_a: assert property (slave |=>
    o_pad_oe[5:3] == 3'h4 && !o_pad_oe[7] && !o_pullup_en[5])
    else $error("slave pin direction wrong");
  ready_out_a: assert property (slave |=> o_pad_out[5] == $past(i_ready_n))
    else $error("ready not on pin 5");
  trig_feed_a: assert property (o_converter_trigger_in == o_ext_interrupt_two)
    else $error("trigger differs from pin 0 feed");
  reset_idle_a: assert property ($rose(i_resetn) |-> !o_pad_oe && !o_pullup_en)
    else $error("pins not idle after reset");
endmodule
bind pmio_port pmio_props u_props (.i_clk, .i_resetn, .i_mode, .i_dualport_slave_enable,
  .i_hw_standby, .i_sw_standby, .i_rd_strobe_n, .i_wr_strobe_n, .i_addr_strobe_n,
  .i_ready_n, .o_pad_out, .o_pad_oe, .o_pullup_en, .o_ext_interrupt_two,
  .o_converter_trigger_in);

// ===== tb/pmio_pad_model.sv
// far side of the port pins: bus devices or host driving the pads
// assumes: bench sets far-side levels and enables; the port wins where it drives
`timescale 1ns/100ps
module pmio_pad_model (
  input wire logic i_clk,
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe,
  input wire logic [7:0] i_pullup_en,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_level
);
  logic [7:0] float_r = 8'h55;
  // an open line wanders, so a stale level never reads as right
  always @(posedge i_clk) float_r <= ~float_r;
  // port drive, then far-side drive, then pull-up, else floating
  assign o_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val)
    | (~i_pad_oe & ~i_ext_en & (i_pullup_en | float_r));
endmodule

// ===== tb/port9_mode_muxed_io_test.sv
// bench for the mode-muxed port: registers over axi4-lite, then pin checks
// assumes: pad model plays the far side; pins 0-2 kept as inputs for feeds
`timescale 1ns/100ps
module port9_mode_muxed_io_test;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [17:0] i_awaddr = 18'h0_0000, i_araddr = 18'h0_0000;
  logic [31:0] i_wdata = 32'h0;
  pmio_pkg::pmio_mode_e i_mode = pmio_pkg::PMIO_SINGLE;
  logic i_dualport_slave_enable = 1'b0, i_hw_standby = 1'b0, i_sw_standby = 1'b0;
  logic i_rd_strobe_n = 1'b1, i_wr_strobe_n = 1'b1, i_addr_strobe_n = 1'b1, i_ready_n = 1'b0;
  logic [7:0] ext = 8'hA5, ext_en = 8'hFF, lvl;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_chip_select_n;
  logic o_output_enable_n, o_write_enable_n, o_bus_wait_n, o_ext_interrupt_zero;
  logic o_ext_interrupt_one, o_ext_interrupt_two, o_converter_trigger_in;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [7:0] o_pad_out, o_pad_oe, o_pullup_en;
  int err_count = 0, num_checks = 0;
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  pmio_port i_dut (.i_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_mode,
    .i_dualport_slave_enable, .i_hw_standby, .i_sw_standby, .i_sysclk_level(1'b0),
    .i_rd_strobe_n, .i_wr_strobe_n, .i_addr_strobe_n, .i_ready_n, .i_pad_in(lvl),
    .o_pad_out, .o_pad_oe, .o_pullup_en, .o_ext_interrupt_zero, .o_ext_interrupt_one,
    .o_ext_interrupt_two, .o_converter_trigger_in, .o_chip_select_n, .o_output_enable_n,
    .o_write_enable_n, .o_bus_wait_n);
  pmio_pad_model u_pads (.i_clk, .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
    .i_pullup_en(o_pullup_en), .i_ext_val(ext), .i_ext_en(ext_en), .o_level(lvl));
  task automatic final_report();
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // ends at a falling edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic reset(input pmio_pkg::pmio_mode_e m, input logic [2:0] s);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    i_mode <= m;
    {i_addr_strobe_n, i_wr_strobe_n, i_rd_strobe_n} <= s;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    wt(6);
  endtask
  // ready and response are sampled on the falling edge before the taking edge
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = o_awready;
      tw = o_wready;
      tb = o_bvalid;
      rs = o_bresp;
      @(posedge i_clk);
      if (ta === 1'b1) i_awvalid <= 1'b0;
      if (tw === 1'b1) i_wvalid <= 1'b0;
    end while (tb !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", rs, r);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] d);
    logic ta, tv;
    logic [31:0] rdat;
    logic [1:0] rs;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = o_arready;
      tv = o_rvalid;
      rdat = o_rdata;
      rs = o_rresp;
      @(posedge i_clk);
      if (ta === 1'b1) i_arvalid <= 1'b0;
    end while (tv !== 1'b1);
    i_rready <= 1'b0;
    chk("rresp", rs, pmio_pkg::PMIO_RESP_OKAY);
    chk("rdata", rdat, d);
  endtask
  // a hang is cut short well beyond the hundred or so cycles needed
  initial begin
    repeat (3000) @(posedge i_clk);
    err_count++;
    final_report();
  end
  initial begin
    reset(pmio_pkg::PMIO_SINGLE, 3'h7);
    chk("oe", o_pad_oe, 8'h00);
    chk("pullup", o_pullup_en, 8'h00);
    rd(pmio_pkg::PMIO_OFF_DIR, 8'h00);
    rd(pmio_pkg::PMIO_OFF_DATA, 8'hA5);
    ext_en <= 8'hBF;
    wr(pmio_pkg::PMIO_OFF_DIR, 8'hB8, pmio_pkg::PMIO_RESP_OKAY);
    wr(pmio_pkg::PMIO_OFF_DATA, 8'h5A, pmio_pkg::PMIO_RESP_OKAY);
    wt(6);
    chk("oe", o_pad_oe, 8'hB8);
    chk("pullup", o_pullup_en, 8'h42);
    chk("latch", o_pad_out & 8'hB8, 8'h18);
    chk("feeds", {o_ext_interrupt_two, o_ext_interrupt_one, o_ext_interrupt_zero}, 3'h5);
    rd(pmio_pkg::PMIO_OFF_DATA, 8'h5D);
    wr(18'h0_0010, 8'hFF, pmio_pkg::PMIO_RESP_SLVERR);
    rd(pmio_pkg::PMIO_OFF_DATA, 8'h5D);
    i_dualport_slave_enable <= 1'b1;
    i_ready_n <= 1'b1;
    wr(pmio_pkg::PMIO_OFF_DIR, 8'h40, pmio_pkg::PMIO_RESP_OKAY);
    wr(pmio_pkg::PMIO_OFF_DATA, 8'hFF, pmio_pkg::PMIO_RESP_OKAY);
    wt(6);
    chk("oe", o_pad_oe, 8'h60);
    chk("pullup", o_pullup_en, 8'h9F);
    chk("ctl", {o_chip_select_n, o_output_enable_n, o_write_enable_n, o_pad_out[6:5]}, 5'h05);
    rd(pmio_pkg::PMIO_OFF_DATA, 8'hA5);
    // both expanded modes, each with its own strobe pattern
    for (int k = 0; k < 2; k++) begin
      i_dualport_slave_enable <= 1'b0;
      reset(k ? pmio_pkg::PMIO_EXP2 : pmio_pkg::PMIO_EXP1, k ? 3'h5 : 3'h2);
      chk("oe", o_pad_oe, 8'h78);
      chk("pullup", o_pullup_en, 8'h00);
      chk("strobes", o_pad_out[5:3], k ? 3'h5 : 3'h2);
      chk("feeds", {o_ext_interrupt_two, o_converter_trigger_in, o_bus_wait_n}, 3'h7);
      @(posedge i_clk);
      i_sw_standby <= 1'b1;
      wt(2);
      chk("standby", {o_pad_oe[6:3], o_pad_out[6:3]}, 8'hFF);
      @(posedge i_clk);
      i_sw_standby <= 1'b0;
      i_hw_standby <= 1'b1;
      wt(2);
      chk("release", {o_pad_oe, o_pullup_en}, 16'h0000);
      @(posedge i_clk);
      i_hw_standby <= 1'b0;
    end
    final_report();
  end
endmodule
